// file: hw/eads_top.sv
// additional data selector: bus registers, sequence stepping and serial command issue
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module eads_top
    import eads_pkg::*;
(
    input wire logic MCLK, // 25 MHz clock
    input wire logic RST_B, // synchronous reset, active low
    input wire logic HSEL, // slave select
    input wire logic [31:0] HADDR, // byte address
    input wire logic [1:0] HTRANS, // transfer type
    input wire logic HWRITE, // write strobe
    input wire logic [2:0] HSIZE, // transfer size
    input wire logic [31:0] HWDATA, // write data
    input wire logic HREADY, // bus ready
    output logic [31:0] HRDATA, // read data
    output logic HREADYOUT, // slave ready
    output logic HRESP, // response, always okay
    input wire logic TRIGGER, // one-cycle trigger pulse
    input wire logic SM_BUSY, // serial master busy
    input wire logic SM_DONE, // serial transfer done pulse
    input wire logic SM_FAIL, // no or bad encoder answer
    input wire logic SM_TYPE2, // encoder reported type II error
    input wire logic SUPPLY_FAULT, // encoder supply fault
    output logic SM_START, // one-cycle transfer start
    output logic SM_ERRRST, // transfer also clears encoder error memory
    output logic SM_PROGRAM, // transfer programs the selection
    output logic [7:0] SM_SEL1, // datum 1 selection code
    output logic [7:0] SM_SEL2, // datum 2 selection code
    output logic ADD_DATA_ON // additional data is being sent
);
    // ******************************
    // helpers
    // ******************************
    function automatic logic code_ok(input logic [7:0] c);
        code_ok = (c <= second_datum_off_code);
    endfunction : code_ok
    function automatic logic is_second(input logic [7:0] c);
        is_second = (c >= second_datum_idle_code);
    endfunction : is_second

    // ******************************
    // bus address phase
    // ******************************
    logic wr_pend_q;
    logic [11:0] addr_q;
    logic [1:0] mode_q;
    logic newrev_q, ifok_q, init_q;
    logic [7:0] sel1_q, sel2_q;
    logic seq_en_q;
    logic [3:0] seq_len_q, seq_idx_q, wr_ptr_q;
    logic [7:0] seq_mem_q [0:9];
    logic [3:0] err_q;
    logic busy_q;
    logic [1:0] prev_mode_q;
    logic [7:0] act1_q, act2_q;
    wire take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ) && (HSIZE == HSIZE_WORD);
    wire polling = (mode_q == EADS_POLL);
    // ******************************
    // write decode
    // ******************************
    wire wr_ctrl = wr_pend_q && (addr_q == REG_CTRL);
    wire wr_sel = wr_pend_q && (addr_q == REG_SELECT);
    wire wr_seqc = wr_pend_q && (addr_q == REG_SEQ_CTRL);
    wire wr_seqd = wr_pend_q && (addr_q == REG_SEQ_DATA);
    wire wr_cmd = wr_pend_q && (addr_q == REG_CMD) && HWDATA[CMD_ERRRST];
    wire [7:0] new1 = HWDATA[7:0];
    wire [7:0] new2 = HWDATA[SEL_SECOND_LSB +: 8];
    wire [3:0] new_len = HWDATA[SEQ_LEN_LSB +: 4];
    // common gate for configuration and error reset, first failing cause wins
    wire [3:0] gate_err = !ifok_q ? wrong_interface_error :
                          !init_q ? axis_uninitialized_error :
                          !newrev_q ? revision_unsupported_error :
                          !polling ? mode_wrong_error : ERR_NONE;
    wire sel_bad = (new1 > first_datum_off_code) || !is_second(new2) || !code_ok(new2);
    wire [3:0] sel_err = (gate_err != ERR_NONE) ? gate_err : sel_bad ? bad_parameter_error : ERR_NONE;
    wire seq_bad = (new_len > SEQ_DEPTH) || (HWDATA[SEQ_EN] && new_len == 4'h0);
    wire [3:0] seqc_err = (gate_err != ERR_NONE) ? gate_err : seq_bad ? bad_parameter_error : ERR_NONE;
    wire seqd_bad = !code_ok(HWDATA[7:0]) || (wr_ptr_q >= SEQ_DEPTH);
    wire [3:0] seqd_err = (gate_err != ERR_NONE) ? gate_err : seqd_bad ? bad_parameter_error : ERR_NONE;
    // error reset refused when master busy, after the gate checks
    wire [3:0] cmd_err = (gate_err != ERR_NONE) ? gate_err :
                         (SM_BUSY || busy_q) ? serial_master_busy_error : ERR_NONE;
    wire leave_poll = (prev_mode_q == EADS_POLL) && !polling;
    wire streaming = !polling;
    wire step = TRIGGER && streaming && seq_en_q && (seq_len_q != 4'h0);
    wire [7:0] seq_code = seq_mem_q[seq_idx_q];
    wire [3:0] idx_next = (seq_idx_q + 4'h1 >= seq_len_q) ? 4'h0 : seq_idx_q + 4'h1;
    // a second-set code replaces datum 2, a first-set code datum 1
    wire [7:0] step1 = is_second(seq_code) ? act1_q : seq_code;
    wire [7:0] step2 = is_second(seq_code) ? seq_code : act2_q;
    wire [3:0] done_err = SUPPLY_FAULT ? encoder_supply_error :
                          SM_FAIL ? transfer_failed_error :
                          SM_TYPE2 ? encoder_type2_error : ERR_NONE;

    // ******************************
    // bus phase tracking
    // ******************************
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            wr_pend_q <= 1'b0;
            addr_q <= 12'h000;
        end else begin
            wr_pend_q <= take && HWRITE;
            if (take) begin
                addr_q <= HADDR[11:0];
            end
        end
    end

    // ******************************
    // configuration registers
    // ******************************
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            mode_q <= EADS_POLL;
            prev_mode_q <= EADS_POLL;
            newrev_q <= 1'b0;
            ifok_q <= 1'b0;
            init_q <= 1'b0;
            sel1_q <= first_datum_idle_code;
            sel2_q <= second_datum_idle_code;
            seq_en_q <= setting_off;
            seq_len_q <= 4'h0;
            wr_ptr_q <= 4'h0;
        end else begin
            prev_mode_q <= mode_q;
            if (wr_ctrl) begin
                mode_q <= HWDATA[CTRL_MODE_LSB +: 2];
                newrev_q <= HWDATA[CTRL_NEWREV];
                ifok_q <= HWDATA[CTRL_IFOK];
                init_q <= HWDATA[CTRL_INIT];
            end
            if (wr_sel && sel_err == ERR_NONE) begin
                sel1_q <= new1;
                sel2_q <= new2;
            end
            if (wr_seqc && seqc_err == ERR_NONE) begin
                seq_en_q <= HWDATA[SEQ_EN];
                seq_len_q <= new_len;
                wr_ptr_q <= 4'h0;
            end else if (wr_seqd && seqd_err == ERR_NONE) begin
                wr_ptr_q <= wr_ptr_q + 4'h1;
            end
        end
    end

    // sequence storage: no reset, loaded only through the data register
    always_ff @(posedge MCLK) begin
        if (wr_seqd && seqd_err == ERR_NONE) begin
            seq_mem_q[wr_ptr_q] <= HWDATA[7:0];
        end
    end

    // ******************************
    // sequence stepping and serial commands
    // ******************************
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            seq_idx_q <= 4'h0;
            act1_q <= first_datum_idle_code;
            act2_q <= second_datum_idle_code;
            SM_START <= 1'b0;
            SM_ERRRST <= 1'b0;
            SM_PROGRAM <= 1'b0;
            busy_q <= 1'b0;
            err_q <= ERR_NONE;
        end else begin
            SM_START <= 1'b0;
            if ((wr_seqc && seqc_err == ERR_NONE) || leave_poll) begin
                seq_idx_q <= 4'h0;
            end else if (step) begin
                seq_idx_q <= idx_next;
            end
            if (leave_poll) begin
                act1_q <= sel1_q;
                act2_q <= sel2_q;
                SM_START <= 1'b1;
                SM_PROGRAM <= 1'b1;
                SM_ERRRST <= 1'b0;
                busy_q <= 1'b1;
            end else if (step && !busy_q) begin
                act1_q <= step1;
                act2_q <= step2;
                SM_START <= 1'b1;
                SM_PROGRAM <= 1'b1;
                SM_ERRRST <= 1'b0;
                busy_q <= 1'b1;
            end else if (wr_cmd && cmd_err == ERR_NONE) begin
                SM_START <= 1'b1;
                SM_ERRRST <= 1'b1;
                SM_PROGRAM <= 1'b0;
                busy_q <= 1'b1;
            end else if (SM_DONE && busy_q) begin
                busy_q <= 1'b0;
            end
            if (wr_sel) begin
                err_q <= sel_err;
            end else if (wr_seqc) begin
                err_q <= seqc_err;
            end else if (wr_seqd) begin
                err_q <= seqd_err;
            end else if (wr_cmd) begin
                err_q <= cmd_err;
            end else if (SM_DONE && busy_q) begin
                err_q <= done_err;
            end
        end
    end

    // ******************************
    // outputs and read data
    // ******************************
    // read data is registered at the address phase edge so it stands during the data phase
    wire [11:0] rd_addr = HADDR[11:0];
    wire [31:0] rd_mux =
        (rd_addr == REG_CTRL) ? {27'h0, init_q, ifok_q, newrev_q, mode_q} :
        (rd_addr == REG_SELECT) ? {16'h0, sel2_q, sel1_q} :
        (rd_addr == REG_SEQ_CTRL) ? {12'h0, seq_idx_q, 4'h0, seq_len_q, 7'h0, seq_en_q} :
        (rd_addr == REG_STATUS) ? {27'h0, busy_q, err_q} :
        (rd_addr == REG_ACTIVE) ? {16'h0, act2_q, act1_q} : 32'h0;
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            HRDATA <= 32'h0;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            SM_SEL1 <= first_datum_idle_code;
            SM_SEL2 <= second_datum_idle_code;
            ADD_DATA_ON <= 1'b0;
        end else begin
            HRDATA <= (take && !HWRITE) ? rd_mux : 32'h0;
            HREADYOUT <= 1'b1;
            HRESP <= HRESP_OKAY[0];
            SM_SEL1 <= act1_q;
            SM_SEL2 <= act2_q;
            ADD_DATA_ON <= streaming && !(act1_q == first_datum_off_code
                                          && act2_q == second_datum_off_code);
        end
    end

    // ******************************
    // checks
    // ******************************
    // a start is a single pulse; a second one would launch a duplicate transfer
    AST_START_ONE_CYCLE: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        SM_START |=> !SM_START
    ) else $error("transfer start lasted more than one cycle");

    // an error reset may only come from a request made while polling on a newer-revision axis
    AST_ERRRST_POLL: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (SM_START && SM_ERRRST)
        |-> $past(polling && newrev_q)
    ) else $error("error reset started outside polling or on an older axis");

    // a busy serial master refuses the error reset and says why
    AST_BUSY_REFUSE: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (wr_cmd && gate_err == ERR_NONE && (SM_BUSY || busy_q))
        |=> (err_q == serial_master_busy_error) && !SM_START
    ) else $error("error reset not refused while master busy");

    // supply fault outranks the other completion errors
    AST_SUPPLY_FIRST: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (SM_DONE && busy_q && SUPPLY_FAULT && !wr_pend_q)
        |=> err_q == encoder_supply_error
    ) else $error("supply fault not reported at transfer end");

    // selection is frozen outside polling
    AST_CFG_ONLY_POLL: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (wr_sel && !polling)
        |=> (sel1_q == $past(sel1_q)) && (sel2_q == $past(sel2_q))
    ) else $error("selection changed outside polling");

    // no additional data leaves the block while polling
    AST_POLL_SILENT: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        polling |=> !ADD_DATA_ON
    ) else $error("additional data on while polling");

    // a disabled sequence never steps
    AST_NO_STEP_OFF: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (!seq_en_q && !wr_seqc && !leave_poll)
        |=> seq_idx_q == $past(seq_idx_q)
    ) else $error("disabled sequence stepped");

    // the index wraps before it runs past the configured length
    AST_IDX_WRAP: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (seq_len_q != 4'h0) |-> (seq_idx_q < seq_len_q)
    ) else $error("sequence index beyond its length");

    // the stored length never exceeds the sequence depth
    AST_LEN_LIMIT: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        seq_len_q <= SEQ_DEPTH
    ) else $error("sequence length above depth");

    // the stored selection always holds codes of the right set
    AST_SEL_LEGAL: assert property (
        @(posedge MCLK) disable iff (!RST_B)
        (sel1_q <= first_datum_off_code)
        && (sel2_q >= second_datum_idle_code)
        && (sel2_q <= second_datum_off_code)
    ) else $error("stored selection outside its code set");
endmodule : eads_top
`default_nettype wire

// file: hw/eads_pkg.sv
// package: register map, codes, modes and error numbers of the additional data selector
package eads_pkg;
    // ******************************
    // register map (byte addresses)
    // ******************************
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_SELECT = 12'h004;
    localparam logic [11:0] REG_SEQ_CTRL = 12'h008;
    localparam logic [11:0] REG_SEQ_DATA = 12'h00c;
    localparam logic [11:0] REG_CMD = 12'h010;
    localparam logic [11:0] REG_STATUS = 12'h014;
    localparam logic [11:0] REG_ACTIVE = 12'h018;
    // ******************************
    // field positions
    // ******************************
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_NEWREV = 2;
    localparam int CTRL_IFOK = 3;
    localparam int CTRL_INIT = 4;
    localparam int SEL_SECOND_LSB = 8;
    localparam int SEQ_EN = 0;
    localparam int SEQ_LEN_LSB = 8;
    localparam int SEQ_IDX_LSB = 16;
    localparam int CMD_ERRRST = 0;
    // ******************************
    // codes
    // ******************************
    localparam logic [7:0] first_datum_idle_code = 8'h00;
    localparam logic [7:0] memory_range_select_code = 8'h07;
    localparam logic [7:0] first_datum_last_code = 8'h0e;
    localparam logic [7:0] first_datum_off_code = 8'h0f;
    localparam logic [7:0] second_datum_idle_code = 8'h10;
    localparam logic [7:0] second_datum_last_code = 8'h19;
    localparam logic [7:0] second_datum_rsvd_code = 8'h1a;
    localparam logic [7:0] second_datum_off_code = 8'h1f;
    localparam logic [3:0] SEQ_DEPTH = 4'ha;
    localparam logic setting_on = 1'b1;
    localparam logic setting_off = 1'b0;
    // ******************************
    // operating modes
    // ******************************
    typedef enum logic [1:0] {
        EADS_POLL = 2'b00,
        EADS_SOFTRT = 2'b01,
        EADS_STREAM = 2'b10,
        EADS_RECORD = 2'b11
    } eads_mode_e;
    // ******************************
    // error codes
    // ******************************
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] bad_parameter_error = 4'h1;
    localparam logic [3:0] wrong_interface_error = 4'h2;
    localparam logic [3:0] axis_uninitialized_error = 4'h3;
    localparam logic [3:0] revision_unsupported_error = 4'h4;
    localparam logic [3:0] serial_master_busy_error = 4'h5;
    localparam logic [3:0] transfer_failed_error = 4'h6;
    localparam logic [3:0] encoder_type2_error = 4'h7;
    localparam logic [3:0] encoder_supply_error = 4'h8;
    localparam logic [3:0] mode_wrong_error = 4'h9;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD = 3'b010;
    localparam logic [1:0] HRESP_OKAY = 2'b00;
endpackage : eads_pkg

// file: verification/eads_sm_model.sv
// serial master and encoder stand-in: answers each started transfer after a latency
`timescale 1ns/10ps
`default_nettype none
module eads_sm_model #(
    parameter int LAT = 4
) (
    input wire logic MCLK, // clock
    input wire logic RST_B, // synchronous reset, active low
    input wire logic SM_START, // transfer start pulse
    input wire logic [1:0] FAULT, // 0 clean, 1 no answer, 2 type II, 3 supply fault
    input wire logic HOLD, // keep the master busy
    output logic SM_BUSY, // master busy
    output logic SM_DONE, // transfer done pulse
    output logic SM_FAIL, // no or bad answer
    output logic SM_TYPE2, // type II error
    output logic SUPPLY_FAULT // supply fault
);
    logic [3:0] cnt_q;
    logic tog_q;
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            cnt_q <= 4'h0;
            SM_DONE <= 1'b0;
            tog_q <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
            SM_DONE <= (cnt_q == 4'h1);
            if (SM_START) begin
                cnt_q <= LAT[3:0];
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
    assign SM_BUSY = HOLD | (cnt_q != 4'h0) | SM_DONE;
    // flags only mean something in the done cycle, so they wander elsewhere
    assign SM_FAIL = SM_DONE ? (FAULT == 2'd1) : tog_q;
    assign SM_TYPE2 = SM_DONE ? (FAULT == 2'd2) : ~tog_q;
    assign SUPPLY_FAULT = SM_DONE ? (FAULT == 2'd3) : tog_q;
endmodule : eads_sm_model
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench of the additional data selector
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import eads_pkg::*;
    logic MCLK = 0, RST_B = 0, HSEL = 0, HWRITE = 0, TRIGGER = 0, HOLD = 0, HREADY;
    logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, r;
    logic [1:0] HTRANS = 0, FAULT = 0;
    logic [2:0] HSIZE = 0;
    logic HREADYOUT, HRESP, SM_BUSY, SM_DONE, SM_FAIL, SM_TYPE2, SUPPLY_FAULT;
    logic SM_START, SM_ERRRST, SM_PROGRAM, ADD_DATA_ON;
    logic [7:0] SM_SEL1, SM_SEL2;
    int err_total = 0, n_tests = 0;
    bit seen;
    assign HREADY = HREADYOUT;
    always #20 MCLK = ~MCLK;
    eads_top DUT (.MCLK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA,
        .HREADYOUT, .HRESP, .TRIGGER, .SM_BUSY, .SM_DONE, .SM_FAIL, .SM_TYPE2, .SUPPLY_FAULT,
        .SM_START, .SM_ERRRST, .SM_PROGRAM, .SM_SEL1, .SM_SEL2, .ADD_DATA_ON);
    eads_sm_model MODEL (.MCLK, .RST_B, .SM_START, .FAULT, .HOLD, .SM_BUSY, .SM_DONE, .SM_FAIL,
        .SM_TYPE2, .SUPPLY_FAULT);
    // ******************************
    // shared tasks
    // ******************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        HSEL <= 1'b1; HADDR <= {20'h0, a}; HTRANS <= HTRANS_NONSEQ; HWRITE <= w; HSIZE <= HSIZE_WORD;
        do @(posedge MCLK); while (HREADY !== 1'b1);
        HSEL <= 1'b0; HTRANS <= 2'b00; HWDATA <= d;
        do @(posedge MCLK); while (HREADY !== 1'b1);
        r = HRDATA;
    endtask : bus
    task status(input logic [3:0] e);
        bus(1'b0, REG_STATUS, 32'h0);
        chk({28'h0, r[3:0]}, {28'h0, e});
    endtask : status
    task go(input logic [1:0] m);
        bus(1'b1, REG_CTRL, 32'h1c | {30'h0, m});
    endtask : go
    // a bounded window long enough for the model to finish any transfer it starts
    task wait_start;
        seen = 0;
        repeat (20) begin
            @(posedge MCLK);
            if (SM_START === 1'b1) seen = 1;
        end
    endtask : wait_start
    task trig;
        TRIGGER <= 1'b1;
        @(posedge MCLK);
        TRIGGER <= 1'b0;
        wait_start;
    endtask : trig
    task print_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    // ******************************
    // scenarios
    // ******************************
    task t_reset;
        chk(SM_SEL1, first_datum_idle_code);
        chk(SM_SEL2, second_datum_idle_code);
        chk(ADD_DATA_ON, 0);
        chk(HRESP, HRESP_OKAY);
        bus(1'b0, 12'h01c, 32'h0);
        chk(r, 0);
        $display("test reset done");
    endtask : t_reset
    task t_select;
        logic [15:0] sw[5] = '{16'h1205, 16'h1205, 16'h1205, 16'h1f05, 16'h1f0f};
        logic [1:0] md[5] = '{2'd1, 2'd2, 2'd3, 2'd1, 2'd2};
        logic on[5] = '{1, 1, 1, 1, 0};
        go(2'd0);
        for (int c = 0; c < 16; c++) begin
            bus(1'b1, REG_SELECT, {16'h0, 8'h10 + c[7:0], c[7:0]});
            status(ERR_NONE);
        end
        bus(1'b1, REG_SELECT, 32'h1010);
        status(bad_parameter_error);
        bus(1'b1, REG_SELECT, 32'h0f00);
        status(bad_parameter_error);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, REG_SELECT, {16'h0, sw[i]});
            go(md[i]);
            wait_start;
            chk(seen, 1);
            chk(SM_PROGRAM, 1);
            chk({SM_SEL2, SM_SEL1}, sw[i]);
            chk(ADD_DATA_ON, on[i]);
            bus(1'b1, REG_SELECT, 32'h1306);
            status(mode_wrong_error);
            go(2'd0);
            repeat (3) @(posedge MCLK);
            chk(ADD_DATA_ON, 0);
        end
        $display("test select done");
    endtask : t_select
    task t_errors;
        logic [31:0] ctl[3] = '{32'h18, 32'h14, 32'h0c};
        logic [3:0] e[3] = '{revision_unsupported_error, wrong_interface_error, axis_uninitialized_error};
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, REG_CTRL, ctl[i]);
            bus(1'b1, REG_SELECT, 32'h1205);
            status(e[i]);
            bus(1'b1, REG_CMD, 32'h1);
            wait_start;
            chk(seen, 0);
            status(e[i]);
        end
        $display("test errors done");
    endtask : t_errors
    task t_errrst;
        logic [3:0] e[4] = '{ERR_NONE, transfer_failed_error, encoder_type2_error, encoder_supply_error};
        go(2'd0);
        for (int f = 0; f < 4; f++) begin
            FAULT <= f[1:0];
            bus(1'b1, REG_CMD, 32'h1);
            wait_start;
            chk(seen, 1);
            chk({SM_ERRRST, SM_PROGRAM}, 2'b10);
            status(e[f]);
        end
        FAULT <= 2'd0;
        HOLD <= 1'b1;
        bus(1'b1, REG_CMD, 32'h1);
        wait_start;
        chk(seen, 0);
        status(serial_master_busy_error);
        HOLD <= 1'b0;
        go(2'd1);
        wait_start;
        bus(1'b1, REG_CMD, 32'h1);
        wait_start;
        chk(seen, 0);
        status(mode_wrong_error);
        go(2'd0);
        $display("test error reset done");
    endtask : t_errrst
    task t_seq;
        logic [7:0] code[3] = '{8'h05, 8'h12, 8'h0f};
        go(2'd0);
        bus(1'b1, REG_SEQ_CTRL, 32'h0b01);
        status(bad_parameter_error);
        bus(1'b1, REG_SEQ_CTRL, 32'h0001);
        status(bad_parameter_error);
        bus(1'b1, REG_SEQ_CTRL, 32'h0a01);
        status(ERR_NONE);
        bus(1'b1, REG_SEQ_CTRL, 32'h0301);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, REG_SEQ_DATA, {24'h0, code[i]});
            status(ERR_NONE);
        end
        go(2'd1);
        wait_start;
        for (int k = 0; k < 7; k++) begin
            bus(1'b0, REG_SEQ_CTRL, 32'h0);
            chk({28'h0, r[19:16]}, k % 3);
            trig;
            chk(code[k % 3] >= 8'h10 ? SM_SEL2 : SM_SEL1, code[k % 3]);
        end
        go(2'd0);
        bus(1'b1, REG_SEQ_CTRL, 32'h0300);
        go(2'd1);
        wait_start;
        trig;
        bus(1'b0, REG_SEQ_CTRL, 32'h0);
        chk({28'h0, r[19:16]}, 0);
        go(2'd0);
        $display("test sequence done");
    endtask : t_seq
    initial begin
        repeat (3) @(posedge MCLK);
        RST_B <= 1'b1;
        @(posedge MCLK);
        t_reset;
        t_select;
        t_errors;
        t_errrst;
        t_seq;
        print_verdict;
    end
    initial begin
        repeat (20000) @(posedge MCLK);
        err_total++;
        print_verdict;
    end
endmodule : testbench
`default_nettype wire
